// >>> common/swt_pkg.sv
// Package: register map, field layouts and types of the trigger block
package swt_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_WAKE_SEL = 12'h040;
   localparam logic [11:0] IDX_SEQ_SEL = 12'h041;
   localparam logic [11:0] IDX_CTRL = 12'h042;
   localparam logic [11:0] IDX_STATUS = 12'h043;
   localparam logic [11:0] IDX_FLAGS = 12'hd50;
   localparam logic [15:0] ADDR_WAKE_SEL = 16'({IDX_WAKE_SEL, 2'b00});
   localparam logic [15:0] ADDR_SEQ_SEL = 16'({IDX_SEQ_SEL, 2'b00});
   localparam logic [15:0] ADDR_CTRL = 16'({IDX_CTRL, 2'b00});
   localparam logic [15:0] ADDR_STATUS = 16'({IDX_STATUS, 2'b00});
   localparam logic [15:0] ADDR_FLAGS = 16'({IDX_FLAGS, 2'b00});

   // Edge positions shared by flags, wake and sequencer selects
   localparam int BIT_JACK_RISE = 2;
   localparam int BIT_JACK_FALL = 3;
   localparam int BIT_PIN_RISE = 4;
   localparam int BIT_PIN_FALL = 5;
   localparam int BIT_CLAMP_RISE = 6;
   localparam int BIT_CLAMP_FALL = 7;
   localparam logic [7:0] EDGE_MASK = 8'hfc;
   localparam logic [7:0] JACK_PIN_MASK = 8'h3c;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;

   localparam logic [31:0] CTRL_RESET = 32'h0002_0016;
   localparam logic [31:0] CTRL_WMASK = 32'h003f_77f7;
   localparam logic [6:0] PIN_FN_LOGIC = 7'h01;
   localparam logic [1:0] SRC_SECOND_CLK = 2'h1;

   // Debounce time measured in slow clock periods, rounded up
   localparam int DB_TIME_US = 100;
   localparam int SLOW_CLK_HZ = 32768;
   localparam int DB_TICKS_I = (DB_TIME_US * SLOW_CLK_HZ + 999999) / 1000000;
   localparam logic [3:0] DB_TICKS = 4'(DB_TICKS_I);

   typedef enum logic [2:0] {
      CLAMP_OFF = 3'b000,
      CLAMP_JACK = 3'b001,
      CLAMP_JACK_N = 3'b010,
      CLAMP_PIN = 3'b011,
      CLAMP_PIN_N = 3'b100,
      CLAMP_AND = 3'b101,
      CLAMP_OR = 3'b110,
      CLAMP_JACK_PIN_N = 3'b111
   } swt_clamp_t;

   typedef enum logic {
      PWR_SLEEP = 1'b0,
      PWR_AWAKE = 1'b1
   } swt_pwr_t;

   typedef struct packed {
      logic [9:0] rsv3;
      logic [1:0] slow_clock_source;
      logic slow_clock_en;
      logic db_clamp;
      logic db_pin;
      logic db_jack;
      logic rsv2;
      logic [2:0] clamp_logic_select;
      logic rsv1;
      logic [6:0] pin_function_code;
      logic rsv0;
      logic pin_direction;
      logic regulator_enable_bit;
      logic jack_enable;
   } swt_ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } swt_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } swt_apb_rsp_t;

   typedef struct packed {
      logic jack_detect_signal;
      logic pin_derived_signal;
      logic mic_clamp_status;
   } swt_sig_t;

endpackage

// >>> hdl/swt_debounce.sv
// Debounce and edge detection for one always-on control signal
module swt_debounce
   import swt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw_in,
   input wire logic db_en,
   input wire logic slow_tick,
   output logic value_out,
   output logic rise_out,
   output logic fall_out
);

   typedef struct packed {
      logic value;
      logic [3:0] cnt;
      logic rise;
      logic fall;
   } swt_db_st_t;

   swt_db_st_t st_reg;
   swt_db_st_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!db_en) begin
         st_next.value = raw_in;
         st_next.cnt = 4'h0;
      end else if (raw_in == st_reg.value) begin
         st_next.cnt = 4'h0;
      end else if (slow_tick) begin
         // Without ticks a changed input is held off indefinitely
         if (st_reg.cnt + 4'h1 >= DB_TICKS) begin
            st_next.value = raw_in;
            st_next.cnt = 4'h0;
         end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
         end
      end
      st_next.rise = st_next.value & ~st_reg.value;
      st_next.fall = ~st_next.value & st_reg.value;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign value_out = st_reg.value;
   assign rise_out = st_reg.rise;
   assign fall_out = st_reg.fall;

   chk_db_bypass: assert property (
      @(posedge pclk) disable iff (!presetn)
      !db_en |=> value_out == $past(raw_in))
      else $error("bypassed input not followed");

   chk_db_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (db_en && !slow_tick) |=> $stable(value_out))
      else $error("debounced value moved without a tick");

   chk_edge_single: assert property (
      @(posedge pclk) disable iff (!presetn)
      rise_out |-> !fall_out && value_out && !$past(value_out))
      else $error("rise pulse without a transition");

endmodule

// >>> hdl/swt_sleep_wake_trigger_control.sv
// Sleep wake-up and sequencer edge-trigger control with APB registers
// Functional notes
// - Enabled jack detect follows jack sense pin
// - Clamp status is selectable jack/pin function
// - Each signal edge sets its own flag
// - Flags sticky, reset zero, write-one clears
// - Wake-select bits pick flags that wake
// - Wake event switches core regulator back on
// - Sequencer-select bits pick flags launching sequences
// - Sequencer launches only in normal operation
// - All three signals go to interrupt controller
// - Debounce timed by slow clock, enabled
// - Only second master clock works in sleep
// - Jack rise sequencer select at bit 2
// - Valid sequencer trigger schedules its sequence
// - Sleep interrupt from jack/pin, held till wake
//
// Decided for this implementation: the APB interface to the registers.
module swt_sleep_wake_trigger_control
   import swt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire swt_apb_req_t apb_req,
   output swt_apb_rsp_t apb_rsp,
   input wire logic jack_sense_pin,
   input wire logic wake_capable_pin,
   input wire logic first_clk_tick,
   input wire logic second_clk_tick,
   input wire logic irq_ctrl_req,
   output logic core_regulator_en,
   output logic seq_launch,
   output logic [7:0] seq_source,
   output swt_sig_t irq_sources,
   output logic irq_req
);

   typedef struct packed {
      logic [7:0] wake_sel;
      logic [7:0] seq_sel;
      logic [7:0] flags;
      swt_ctrl_t ctrl;
      swt_pwr_t pwr;
      logic regulator;
      swt_apb_rsp_t rsp;
      logic seq_launch;
      logic [7:0] seq_src;
      swt_sig_t srcs;
      logic irq;
   } swt_top_st_t;

   swt_top_st_t st_reg;
   swt_top_st_t st_next;

   logic jack_raw;
   logic pin_raw;
   logic clamp_raw;
   logic slow_tick;
   logic asleep;
   logic jack_val;
   logic jack_rise;
   logic jack_fall;
   logic pin_val;
   logic pin_rise;
   logic pin_fall;
   logic clamp_val;
   logic clamp_rise;
   logic clamp_fall;
   logic [7:0] edge_set;
   logic [7:0] w1c;
   logic [7:0] wake_hit;
   logic [7:0] seq_hit;
   logic setup;
   logic access;
   logic hit;
   logic [31:0] rdata;
   logic [31:0] status;

   assign asleep = (st_reg.pwr == PWR_SLEEP);

   // Input conditioning ahead of the debouncers
   always_comb begin
      jack_raw = jack_sense_pin & st_reg.ctrl.jack_enable;
      // Pin only counts when configured as a logic-level input
      pin_raw = wake_capable_pin & st_reg.ctrl.pin_direction &
                (st_reg.ctrl.pin_function_code == PIN_FN_LOGIC);
      case (swt_clamp_t'(st_reg.ctrl.clamp_logic_select))
         CLAMP_OFF: clamp_raw = 1'b0;
         CLAMP_JACK: clamp_raw = jack_raw;
         CLAMP_JACK_N: clamp_raw = ~jack_raw;
         CLAMP_PIN: clamp_raw = pin_raw;
         CLAMP_PIN_N: clamp_raw = ~pin_raw;
         CLAMP_AND: clamp_raw = jack_raw & pin_raw;
         CLAMP_OR: clamp_raw = jack_raw | pin_raw;
         CLAMP_JACK_PIN_N: clamp_raw = jack_raw & ~pin_raw;
         default: clamp_raw = 1'b0;
      endcase
   end

   // First master clock is dead in sleep, so its ticks are ignored there
   always_comb begin
      if (!st_reg.ctrl.slow_clock_en) begin
         slow_tick = 1'b0;
      end else if (st_reg.ctrl.slow_clock_source == SRC_SECOND_CLK) begin
         slow_tick = second_clk_tick;
      end else begin
         slow_tick = first_clk_tick & ~asleep;
      end
   end

   swt_debounce u_db_jack (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(jack_raw),
      .db_en(st_reg.ctrl.db_jack),
      .slow_tick(slow_tick),
      .value_out(jack_val),
      .rise_out(jack_rise),
      .fall_out(jack_fall)
   );

   swt_debounce u_db_pin (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(pin_raw),
      .db_en(st_reg.ctrl.db_pin),
      .slow_tick(slow_tick),
      .value_out(pin_val),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   swt_debounce u_db_clamp (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(clamp_raw),
      .db_en(st_reg.ctrl.db_clamp),
      .slow_tick(slow_tick),
      .value_out(clamp_val),
      .rise_out(clamp_rise),
      .fall_out(clamp_fall)
   );

   always_comb begin
      edge_set = 8'h00;
      edge_set[BIT_JACK_RISE] = jack_rise;
      edge_set[BIT_JACK_FALL] = jack_fall;
      edge_set[BIT_PIN_RISE] = pin_rise;
      edge_set[BIT_PIN_FALL] = pin_fall;
      edge_set[BIT_CLAMP_RISE] = clamp_rise;
      edge_set[BIT_CLAMP_FALL] = clamp_fall;
   end

   assign status = {26'h0, st_reg.irq, st_reg.regulator, asleep,
                    clamp_val, pin_val, jack_val};

   // APB decode; the control interface is refused while asleep
   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable & st_reg.rsp.pready;

   always_comb begin
      hit = ~asleep;
      rdata = 32'h0;
      case (apb_req.paddr)
         ADDR_WAKE_SEL: rdata = {24'h0, st_reg.wake_sel};
         ADDR_SEQ_SEL: rdata = {24'h0, st_reg.seq_sel};
         ADDR_CTRL: rdata = st_reg.ctrl;
         ADDR_STATUS: rdata = status;
         ADDR_FLAGS: rdata = {24'h0, st_reg.flags};
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      w1c = 8'h00;
      if (access && apb_req.pwrite && !st_reg.rsp.pslverr &&
          apb_req.paddr == ADDR_FLAGS) begin
         w1c = apb_req.pwdata[7:0] & EDGE_MASK;
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.rsp.pready = setup;
      if (setup) begin
         st_next.rsp.prdata = hit ? rdata : 32'h0;
         st_next.rsp.pslverr = ~hit;
      end
      if (access && apb_req.pwrite && !st_reg.rsp.pslverr) begin
         case (apb_req.paddr)
            ADDR_WAKE_SEL:
               st_next.wake_sel = apb_req.pwdata[7:0] & EDGE_MASK;
            ADDR_SEQ_SEL:
               st_next.seq_sel = apb_req.pwdata[7:0] & EDGE_MASK;
            ADDR_CTRL:
               st_next.ctrl = apb_req.pwdata & CTRL_WMASK;
            default: st_next.ctrl = st_reg.ctrl;
         endcase
      end

      // Set wins over a simultaneous clear
      st_next.flags = (st_reg.flags & ~w1c) | edge_set;

      // A held wake-selected flag keeps the regulator on; clearing it may drop supply
      wake_hit = st_next.flags & st_reg.wake_sel;
      case (st_reg.pwr)
         PWR_AWAKE: begin
            if (!st_next.ctrl.regulator_enable_bit && wake_hit == 8'h00) begin
               st_next.pwr = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (wake_hit != 8'h00 || st_next.ctrl.regulator_enable_bit) begin
               st_next.pwr = PWR_AWAKE;
            end
         end
         default: st_next.pwr = PWR_AWAKE;
      endcase
      st_next.regulator = (st_next.pwr == PWR_AWAKE);

      // The waking edge finds the block asleep and launches nothing
      seq_hit = edge_set & st_reg.seq_sel;
      st_next.seq_launch = ~asleep & (seq_hit != 8'h00);
      st_next.seq_src = asleep ? 8'h00 : seq_hit;

      st_next.srcs.jack_detect_signal = jack_val;
      st_next.srcs.pin_derived_signal = pin_val;
      st_next.srcs.mic_clamp_status = clamp_val;

      if (asleep) begin
         // Only jack or pin edges may raise it, and it holds till wake
         st_next.irq = st_reg.irq |
                       ((edge_set & JACK_PIN_MASK) != 8'h00);
      end else begin
         st_next.irq = irq_ctrl_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.wake_sel <= SEL_RESET;
         st_reg.seq_sel <= SEL_RESET;
         st_reg.flags <= FLAG_RESET;
         st_reg.ctrl <= CTRL_RESET;
         st_reg.pwr <= PWR_AWAKE;
         st_reg.regulator <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign apb_rsp = st_reg.rsp;
   assign core_regulator_en = st_reg.regulator;
   assign seq_launch = st_reg.seq_launch;
   assign seq_source = st_reg.seq_src;
   assign irq_sources = st_reg.srcs;
   assign irq_req = st_reg.irq;

   chk_flag_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($past(st_reg.flags) & ~st_reg.flags & ~$past(w1c)) == 8'h00)
      else $error("edge flag cleared without a write of one");

   chk_edge_sets_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      jack_rise |=> st_reg.flags[BIT_JACK_RISE])
      else $error("jack rise did not set its flag");

   chk_clamp_fall_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      clamp_fall |=> st_reg.flags[BIT_CLAMP_FALL])
      else $error("clamp fall did not set its flag");

   // Covers every edge, including one that meets a write-one clear
   chk_edge_flags_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      edge_set != 8'h00
      |=> (st_reg.flags & $past(edge_set)) == $past(edge_set))
      else $error("edge did not set its flag");

   chk_seq_source: assert property (
      @(posedge pclk) disable iff (!presetn)
      seq_launch == (seq_source != 8'h00))
      else $error("sequence source without launch");

   chk_wake_regulator: assert property (
      @(posedge pclk) disable iff (!presetn)
      (asleep && (edge_set & st_reg.wake_sel) != 8'h00)
      |=> core_regulator_en && !asleep)
      else $error("wake edge did not restore regulator");

   chk_no_seq_asleep: assert property (
      @(posedge pclk) disable iff (!presetn)
      seq_launch |-> $past(st_reg.pwr) == PWR_AWAKE)
      else $error("sequence launched from sleep");

   chk_seq_launch: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!asleep && jack_rise && st_reg.seq_sel[BIT_JACK_RISE])
      |=> seq_launch && seq_source[BIT_JACK_RISE])
      else $error("selected edge did not launch a sequence");

   chk_irq_hold_sleep: assert property (
      @(posedge pclk) disable iff (!presetn)
      (asleep && irq_req) |=> irq_req)
      else $error("interrupt released while asleep");

   chk_irq_sleep_src: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($rose(irq_req) && $past(asleep))
      |-> $past((edge_set & JACK_PIN_MASK) != 8'h00))
      else $error("sleep interrupt without jack or pin edge");

   chk_jack_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_reg.ctrl.jack_enable && !st_reg.ctrl.db_jack)
      |=> jack_val == $past(jack_sense_pin))
      else $error("jack detect does not follow sense pin");

   chk_sleep_clock: assert property (
      @(posedge pclk) disable iff (!presetn)
      (asleep && st_reg.ctrl.slow_clock_source != SRC_SECOND_CLK)
      |-> !slow_tick)
      else $error("first master clock ticked in sleep");

   cov_wake: cover property (
      @(posedge pclk) disable iff (!presetn)
      asleep ##1 !asleep);

   cov_seq: cover property (
      @(posedge pclk) disable iff (!presetn)
      seq_launch);

   cov_clear: cover property (
      @(posedge pclk) disable iff (!presetn)
      w1c != 8'h00);

   cov_sleep_irq: cover property (
      @(posedge pclk) disable iff (!presetn)
      asleep && irq_req);

endmodule

// >>> verification/swt_far_side_model.sv
// Far-side model: jack sense, button pin and both slow clock tick sources
module swt_far_side_model
   import swt_pkg::*;
#(
   parameter int TICK_DIV = 610
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic jack_lvl,
   input wire logic pin_lvl,
   output logic jack_sense_pin,
   output logic wake_capable_pin,
   output logic first_clk_tick,
   output logic second_clk_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // Levels are clean; bouncing is left to the debounce scenario timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         jack_sense_pin <= 1'b0;
         wake_capable_pin <= 1'b0;
         first_clk_tick <= 1'b0;
         second_clk_tick <= 1'b0;
      end else begin
         cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
         jack_sense_pin <= jack_lvl;
         wake_capable_pin <= pin_lvl;
         // Second clock ticks all the time, sleep included
         second_clk_tick <= (cnt == 0);
         // First clock sits out of phase so a wrong source shows a shift
         first_clk_tick <= (cnt == TICK_DIV / 3);
      end
   end
endmodule

// >>> verification/tb_sleep_wake_trigger_control.sv
// Self-checking bench for the sleep wake-up trigger block
module tb_sleep_wake_trigger_control
   import swt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 610;
   logic pclk, presetn, jack_lvl, pin_lvl, irq_ctrl_req;
   logic jack_sense_pin, wake_capable_pin, first_clk_tick, second_clk_tick;
   logic core_regulator_en, seq_launch, irq_req;
   logic [7:0] seq_source, acc, e;
   logic [31:0] rng, q, r;
   logic err, j1, p1;
   logic [2:0] m;
   swt_apb_req_t req;
   swt_apb_rsp_t rsp;
   swt_sig_t irq_sources;
   int mismatches, num_checks, cycles, n;

   swt_sleep_wake_trigger_control uut (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .jack_sense_pin(jack_sense_pin),
      .wake_capable_pin(wake_capable_pin), .first_clk_tick(first_clk_tick),
      .second_clk_tick(second_clk_tick), .irq_ctrl_req(irq_ctrl_req),
      .core_regulator_en(core_regulator_en), .seq_launch(seq_launch),
      .seq_source(seq_source), .irq_sources(irq_sources), .irq_req(irq_req));
   swt_far_side_model #(.TICK_DIV(DIV)) far (.pclk(pclk), .presetn(presetn),
      .jack_lvl(jack_lvl), .pin_lvl(pin_lvl), .jack_sense_pin(jack_sense_pin),
      .wake_capable_pin(wake_capable_pin), .first_clk_tick(first_clk_tick),
      .second_clk_tick(second_clk_tick));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (seq_launch === 1'b1) acc |= seq_source;
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic clamp_f(logic [2:0] md, logic j, logic p);
      logic [7:0] t;
      t = {j & ~p, j | p, j & p, ~p, p, ~j, j, 1'b0};
      return t[md];
   endfunction
   function automatic logic [7:0] edges(logic [2:0] md, logic j0, p0, j, p);
      logic c0, c;
      c0 = clamp_f(md, j0, p0);
      c = clamp_f(md, j, p);
      return {c0 & ~c, ~c0 & c, p0 & ~p, ~p0 & p, j0 & ~j, ~j0 & j, 2'b00};
   endfunction
   // Jack enabled, pin as logic input, regulator held on by software
   function automatic logic [31:0] base(logic [2:0] md);
      return 32'h0000_0017 | {17'h0, md, 12'h000};
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Request held until pready is seen high, released after that edge
   task automatic apb(input logic wr, input logic [15:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // Pready, read data and error are all taken at one rising edge
      do begin
         @(posedge pclk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      q = rsp.prdata;
      err = rsp.pslverr;
      if (k >= 20) chk(0, 1, "no pready");
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, string s);
      apb(1'b0, a, 32'h0);
      chk(q, exp, s);
   endtask
   task automatic pins(input logic j, p);
      jack_lvl <= j;
      pin_lvl <= p;
      repeat (5) @(posedge pclk);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      rng = 32'h3e46;
      presetn = 1'b0;
      req = '0;
      jack_lvl = 1'b0;
      pin_lvl = 1'b0;
      irq_ctrl_req = 1'b0;
      acc = 8'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_WAKE_SEL, 32'h0, "wake reset");
      rd(ADDR_SEQ_SEL, 32'h0, "seq reset");
      rd(ADDR_FLAGS, 32'h0, "flag reset");
      rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
      apb(1'b0, 16'h0200, 32'h0);
      chk(32'(err), 32'h1, "unmapped read");
      apb(1'b1, ADDR_SEQ_SEL, 32'h0000_00ff);
      rd(ADDR_SEQ_SEL, 32'h0000_00fc, "seq sel");
      for (int i = 0; i < 24; i++) begin
         r = xs();
         m = r[2:0];
         apb(1'b1, ADDR_CTRL, base(m));
         repeat (4) @(posedge pclk);
         apb(1'b1, ADDR_FLAGS, 32'h0000_00fc);
         acc = 8'h00;
         r = xs();
         j1 = r[0];
         p1 = r[1];
         e = edges(m, jack_lvl, pin_lvl, j1, p1);
         irq_ctrl_req <= r[2];
         pins(j1, p1);
         chk(32'(acc), 32'(e), "sequence sources");
         rd(ADDR_FLAGS, 32'(e), "edge flags");
         chk(32'(irq_sources), 32'({j1, p1, clamp_f(m, j1, p1)}),
             "irq sources");
         chk(32'(irq_req), 32'(irq_ctrl_req), "irq follows");
      end
      irq_ctrl_req <= 1'b0;
      apb(1'b1, ADDR_CTRL, base(3'h0));
      pins(1'b0, 1'b0);
      apb(1'b1, ADDR_FLAGS, 32'h0000_00fc);
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      rd(ADDR_FLAGS, 32'h0000_000c, "both jack flags");
      apb(1'b1, ADDR_FLAGS, 32'h0000_0008);
      rd(ADDR_FLAGS, 32'h0000_0004, "one-bit clear");
      apb(1'b1, ADDR_FLAGS, 32'h0000_0000);
      rd(ADDR_FLAGS, 32'h0000_0004, "zero write");
      // Sleep with jack fall as the only wake source
      pins(1'b1, 1'b0);
      apb(1'b1, ADDR_FLAGS, 32'h0000_00fc);
      apb(1'b1, ADDR_WAKE_SEL, 32'h0000_0008);
      rd(ADDR_WAKE_SEL, 32'h0000_0008, "wake sel");
      apb(1'b1, ADDR_CTRL, base(3'h0) & ~32'h2);
      repeat (3) @(posedge pclk);
      chk(32'(core_regulator_en), 32'h0, "asleep");
      chk(32'(irq_req), 32'h0, "quiet irq asleep");
      apb(1'b0, ADDR_WAKE_SEL, 32'h0);
      chk(32'(err), 32'h1, "access in sleep");
      acc = 8'h00;
      pins(1'b1, 1'b1);
      chk(32'(core_regulator_en), 32'h0, "unselected edge");
      chk(32'(irq_req), 32'h1, "pin irq asleep");
      pins(1'b0, 1'b1);
      chk(32'(core_regulator_en), 32'h1, "woken");
      chk(32'(acc), 32'h0, "no launch on wake");
      chk(32'(irq_req), 32'h0, "irq released");
      apb(1'b1, ADDR_CTRL, base(3'h0));
      apb(1'b1, ADDR_FLAGS, 32'h0000_00fc);
      repeat (3) @(posedge pclk);
      chk(32'(core_regulator_en), 32'h1, "stays awake");
      // Debounce on jack timed by second clock ticks
      apb(1'b1, ADDR_CTRL, base(3'h0) | 32'h0019_0000);
      jack_lvl <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (irq_sources.jack_detect_signal !== 1'b1 && n < 6 * DIV);
      chk(32'(n > 3 * DIV && n < 4 * DIV + 10), 32'h1, "debounce");
      rd(ADDR_STATUS, 32'h0000_0013, "status");
      give_verdict();
   end
endmodule
